// file: cwss_defines.vh
// Register map, field positions, reset values and timing counts of the wake-up sequencer.
`ifndef CWSS_DEFINES_VH
`define CWSS_DEFINES_VH
`define CWSS_ADDR_W 8
`define CWSS_OFS_CTRL 8'h00
`define CWSS_OFS_STATUS 8'h04
`define CWSS_OFS_FRAME 8'h08
`define CWSS_OFS_EVENT 8'h0C
`define CWSS_CTRL_DONE_EN 0
`define CWSS_CTRL_DONE_PH_LO 1
`define CWSS_CTRL_DONE_PH_HI 2
`define CWSS_CTRL_EARLY_EN 3
`define CWSS_CTRL_SIG_AUTH 4
`define CWSS_CTRL_TRANSP 5
`define CWSS_CTRL_W 6
`define CWSS_CTRL_RST 6'h07
`define CWSS_RESP_OKAY 2'h0
`define CWSS_RESP_SLVERR 2'h2
`define CWSS_NOOP_A 8'h00
`define CWSS_NOOP_B 8'h7F
`define CWSS_NOOP_C 8'hFF
`define CWSS_RELOAD_FRAME 32'h80000A00
`define CWSS_CLK_MHZ 200
`define CWSS_T_INIT_NS 1000
`define CWSS_INIT_CYC ((`CWSS_T_INIT_NS * `CWSS_CLK_MHZ + 999) / 1000)
`endif

// file: cwss_sequencer.v
// Configuration modal states, four-phase wake-up, early I/O release and command framing.
`timescale 1ns/1ps
`include "cwss_defines.vh"

module cwss_sequencer #(
	parameter BANK_W = 8,
	parameter INIT_CYC = `CWSS_INIT_CYC
) (
	// Clock, reset and clock enable.
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire ce_i,
	// AXI4-Lite register slave.
	input wire [`CWSS_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [`CWSS_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Device pins.
	input wire reprogram_request_n_i,
	input wire init_status_n_i,
	output wire init_status_n_o,
	output wire init_status_n_oe_o,
	input wire done_pin_i,
	output wire done_pin_o,
	output wire done_pin_oe_o,
	input wire supply_low_i,
	// Internal configuration engine status.
	input wire watchdog_trip_i,
	input wire reload_other_port_i,
	input wire partial_ok_i,
	input wire config_ok_i,
	input wire remainder_ok_i,
	input wire auth_pending_i,
	input wire bank_io_loaded_i,
	// Bank I/O early release.
	input wire [BANK_W-1:0] bank_reg_async_i,
	input wire [BANK_W-1:0] bank_reg_set_i,
	input wire [BANK_W-1:0] bank_cfg_pin_i,
	output reg [BANK_W-1:0] bank_early_oe_o,
	output reg [BANK_W-1:0] bank_early_level_o,
	// Global strobes and I/O control.
	output wire global_set_reset_n_o,
	output wire global_write_enable_o,
	output wire global_output_enable_o,
	output reg sys_io_enable_o,
	output wire [2:0] modal_state_o,
	output wire user_mode_o,
	// Command byte stream.
	input wire cmd_valid_i,
	input wire [7:0] cmd_byte_i,
	input wire cmd_prog_qual_i,
	input wire cmd_last_i,
	output wire cmd_ready_o,
	output reg [31:0] cmd_frame_o,
	output reg cmd_frame_valid_o,
	output reg cmd_nullified_o,
	output reg [7:0] cmd_payload_o,
	output reg cmd_payload_valid_o,
	// Non-volatile read path.
	input wire nv_read_i,
	input wire nv_shadowed_i,
	input wire [31:0] nv_array_data_i,
	input wire [31:0] nv_shadow_data_i,
	output reg [31:0] nv_read_data_o,
	output reg nv_read_valid_o
);
	localparam ST_UNPROG = 3'h0;
	localparam ST_CONFIG = 3'h1;
	localparam ST_PCOMP = 3'h2;
	localparam ST_POPER = 3'h3;
	localparam ST_COMPL = 3'h4;
	localparam ST_OPER = 3'h5;
	localparam [2:0] WAKE_END = 3'h4;
	localparam [15:0] INIT_LIM = INIT_CYC[15:0];
	reg [1:0] rst_sync_ff, prog_sync_ff, init_sync_ff, done_sync_ff, vlow_sync_ff, hdr_idx_ff;
	reg [2:0] state_ff, nxt_state, wake_step_ff;
	reg [15:0] init_cnt_ff;
	reg prog_prev_ff, gsr_rel_ff, gwe_rel_ff, goe_rel_ff, done_rel_ff, early_rel_ff;
	reg in_data_ff, qual_ff, reload_ff;
	reg [`CWSS_CTRL_W-1:0] ctrl_ff;
	reg [23:0] hdr_ff;
	reg [3:0] exit_cause_ff;
	wire rst_n, done_en, early_allowed, done_high, prog_fall, reinit, init_timer_done;
	wire can_adv, null_state, wr_go, rd_go;
	wire [1:0] done_phase;
	wire [31:0] frame_full;

	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_ff <= 2'h0;
		end else begin
			rst_sync_ff <= {rst_sync_ff[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_ff[1];
	// Pins are asynchronous to the configuration clock and pass two flops first.
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			prog_sync_ff <= 2'h3;
			init_sync_ff <= 2'h0;
			done_sync_ff <= 2'h0;
			vlow_sync_ff <= 2'h0;
			prog_prev_ff <= 1'b1;
		end else if (ce_i) begin
			prog_sync_ff <= {prog_sync_ff[0], reprogram_request_n_i};
			init_sync_ff <= {init_sync_ff[0], init_status_n_i};
			done_sync_ff <= {done_sync_ff[0], done_pin_i};
			vlow_sync_ff <= {vlow_sync_ff[0], supply_low_i};
			prog_prev_ff <= prog_sync_ff[1];
		end
	end

	assign done_en = ctrl_ff[`CWSS_CTRL_DONE_EN];
	assign done_phase = ctrl_ff[`CWSS_CTRL_DONE_PH_HI:`CWSS_CTRL_DONE_PH_LO];
	assign done_high = done_sync_ff[1];
	assign prog_fall = prog_prev_ff & ~prog_sync_ff[1];
	// A power dip is treated like a reprogram request: it restarts initialisation but keeps the control register.
	assign reinit = prog_fall | reload_ff | reload_other_port_i | vlow_sync_ff[1] |
		(watchdog_trip_i & (state_ff == ST_OPER));
	assign init_timer_done = (init_cnt_ff == INIT_LIM);
	assign can_adv = ~done_en | ~done_rel_ff | done_high;
	assign early_allowed = ctrl_ff[`CWSS_CTRL_EARLY_EN] & ~ctrl_ff[`CWSS_CTRL_SIG_AUTH];
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_UNPROG: begin
				if (init_timer_done && init_sync_ff[1] && prog_sync_ff[1]) begin
					nxt_state = ST_CONFIG;
				end
			end
			ST_CONFIG: begin
				if (partial_ok_i) begin
					nxt_state = ST_PCOMP;
				end
			end
			ST_PCOMP: begin
				if (!auth_pending_i) begin
					nxt_state = ST_POPER;
				end
			end
			ST_POPER: begin
				if (remainder_ok_i && config_ok_i) begin
					nxt_state = ST_COMPL;
				end
			end
			ST_COMPL: begin
				if (wake_step_ff == WAKE_END) begin
					nxt_state = ST_OPER;
				end
			end
			ST_OPER: nxt_state = ST_OPER;
			default: nxt_state = ST_UNPROG;
		endcase
		if (reinit) begin
			nxt_state = ST_UNPROG;
		end
	end

	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			state_ff <= ST_UNPROG;
			init_cnt_ff <= 16'h0000;
			wake_step_ff <= 3'h0;
			gsr_rel_ff <= 1'b0;
			gwe_rel_ff <= 1'b0;
			goe_rel_ff <= 1'b0;
			done_rel_ff <= 1'b0;
			early_rel_ff <= 1'b0;
		end else if (ce_i) begin
			state_ff <= nxt_state;
			if (reinit) begin
				init_cnt_ff <= 16'h0000;
				wake_step_ff <= 3'h0;
				gsr_rel_ff <= 1'b0;
				gwe_rel_ff <= 1'b0;
				goe_rel_ff <= 1'b0;
				done_rel_ff <= 1'b0;
				early_rel_ff <= 1'b0;
			end else begin
				if (state_ff == ST_UNPROG && !init_timer_done) begin
					init_cnt_ff <= init_cnt_ff + 16'h0001;
				end
				if (state_ff == ST_CONFIG && early_allowed && bank_io_loaded_i) begin
					early_rel_ff <= 1'b1;
				end
				// The done release takes its own step so the pin is seen before moving on.
				if (state_ff == ST_COMPL && config_ok_i && !auth_pending_i &&
					wake_step_ff != WAKE_END) begin
					if (wake_step_ff[1:0] == done_phase && !done_rel_ff) begin
						done_rel_ff <= 1'b1;
					end else if (can_adv) begin
						wake_step_ff <= wake_step_ff + 3'h1;
						case (wake_step_ff)
							3'h0: goe_rel_ff <= 1'b1;
							3'h1: gsr_rel_ff <= 1'b1;
							3'h2: gwe_rel_ff <= 1'b1;
							default: gwe_rel_ff <= gwe_rel_ff;
						endcase
					end
				end
			end
		end
	end

	assign global_set_reset_n_o = gsr_rel_ff;
	assign global_write_enable_o = gwe_rel_ff;
	assign global_output_enable_o = goe_rel_ff;
	assign modal_state_o = state_ff;
	assign user_mode_o = (state_ff == ST_OPER);
	// Open-drain pins: drive zero or let the board pull-up win.
	assign init_status_n_o = 1'b0;
	assign init_status_n_oe_o = (state_ff == ST_UNPROG) & ~init_timer_done;
	assign done_pin_o = 1'b0;
	assign done_pin_oe_o = ~done_rel_ff;
	// System I/O enable and the per-pin early release outputs are registered.
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			sys_io_enable_o <= 1'b0;
			bank_early_oe_o <= {BANK_W{1'b0}};
			bank_early_level_o <= {BANK_W{1'b0}};
		end else if (ce_i) begin
			case (state_ff)
				ST_UNPROG: sys_io_enable_o <= 1'b0;
				ST_CONFIG: sys_io_enable_o <= ctrl_ff[`CWSS_CTRL_TRANSP];
				ST_POPER: sys_io_enable_o <= 1'b1;
				default: sys_io_enable_o <= goe_rel_ff;
			endcase
			// Turning authentication on later withdraws an early release already granted.
			bank_early_oe_o <= {BANK_W{early_rel_ff & early_allowed & ~goe_rel_ff}} &
				bank_reg_async_i & ~bank_cfg_pin_i;
			bank_early_level_o <= bank_reg_set_i;
		end
	end

	// Command framing: no-ops are dropped, then four header bytes, then data.
	assign cmd_ready_o = 1'b1;
	assign null_state = (state_ff == ST_UNPROG) | (state_ff == ST_OPER);
	assign frame_full = {hdr_ff, cmd_byte_i};

	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			hdr_idx_ff <= 2'h0;
			in_data_ff <= 1'b0;
			hdr_ff <= 24'h000000;
			qual_ff <= 1'b0;
			reload_ff <= 1'b0;
			cmd_frame_o <= 32'h00000000;
			cmd_frame_valid_o <= 1'b0;
			cmd_nullified_o <= 1'b0;
			cmd_payload_o <= 8'h00;
			cmd_payload_valid_o <= 1'b0;
		end else if (ce_i) begin
			cmd_frame_valid_o <= 1'b0;
			cmd_payload_valid_o <= 1'b0;
			reload_ff <= 1'b0;
			if (cmd_valid_i) begin
				if (in_data_ff) begin
					cmd_payload_o <= cmd_byte_i;
					cmd_payload_valid_o <= ~cmd_nullified_o;
					in_data_ff <= ~cmd_last_i;
				end else if (hdr_idx_ff == 2'h0) begin
					if (cmd_byte_i != `CWSS_NOOP_A && cmd_byte_i != `CWSS_NOOP_B &&
						cmd_byte_i != `CWSS_NOOP_C) begin
						hdr_ff <= {16'h0000, cmd_byte_i};
						qual_ff <= cmd_prog_qual_i;
						hdr_idx_ff <= 2'h1;
					end
				end else if (hdr_idx_ff != 2'h3) begin
					hdr_ff <= {hdr_ff[15:0], cmd_byte_i};
					hdr_idx_ff <= hdr_idx_ff + 2'h1;
				end else begin
					hdr_idx_ff <= 2'h0;
					in_data_ff <= ~cmd_last_i;
					cmd_frame_o <= frame_full;
					cmd_frame_valid_o <= 1'b1;
					cmd_nullified_o <= qual_ff & null_state;
					reload_ff <= (frame_full == `CWSS_RELOAD_FRAME);
				end
			end
		end
	end

	// Non-volatile reads return the shadow copy where one exists.
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			nv_read_data_o <= 32'h00000000;
			nv_read_valid_o <= 1'b0;
		end else if (ce_i) begin
			nv_read_valid_o <= nv_read_i;
			if (nv_read_i) begin
				nv_read_data_o <= nv_shadowed_i ? nv_shadow_data_i : nv_array_data_i;
			end
		end
	end

	// Exit cause record: set wins over a software clear in the same cycle.
	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			exit_cause_ff <= 4'h0;
		end else if (ce_i) begin
			exit_cause_ff <= (exit_cause_ff & ~((wr_go && s_axi_awaddr == `CWSS_OFS_EVENT &&
				s_axi_wstrb[0]) ? s_axi_wdata[3:0] : 4'h0)) |
				{watchdog_trip_i & (state_ff == ST_OPER), vlow_sync_ff[1],
				reload_ff | reload_other_port_i, prog_fall};
		end
	end

	// AXI4-Lite slave: address and data are taken together, answer next cycle.
	assign wr_go = ce_i & s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready = wr_go;
	assign rd_go = ce_i & s_axi_arvalid & ~s_axi_rvalid;
	assign s_axi_arready = rd_go;

	always @(posedge clk_sys_i or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_ff <= `CWSS_CTRL_RST;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `CWSS_RESP_OKAY;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `CWSS_RESP_OKAY;
			s_axi_rdata <= 32'h00000000;
		end else if (ce_i) begin
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
			if (wr_go) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `CWSS_RESP_OKAY;
				if (s_axi_awaddr == `CWSS_OFS_CTRL) begin
					if (s_axi_wstrb[0]) begin
						ctrl_ff <= s_axi_wdata[`CWSS_CTRL_W-1:0];
					end
				end else if (s_axi_awaddr != `CWSS_OFS_EVENT) begin
					s_axi_bresp <= `CWSS_RESP_SLVERR;
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `CWSS_RESP_OKAY;
				case (s_axi_araddr)
					`CWSS_OFS_CTRL: s_axi_rdata <= {26'h0000000, ctrl_ff};
					`CWSS_OFS_STATUS: s_axi_rdata <= {16'h0000, early_rel_ff, done_high,
						init_sync_ff[1], done_rel_ff, goe_rel_ff, gwe_rel_ff, gsr_rel_ff,
						wake_step_ff, 3'h0, state_ff};
					`CWSS_OFS_FRAME: s_axi_rdata <= cmd_frame_o;
					`CWSS_OFS_EVENT: s_axi_rdata <= {28'h0000000, exit_cause_ff};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `CWSS_RESP_SLVERR;
					end
				endcase
			end
		end
	end
endmodule

// file: cwss_properties.sv
// Concurrent port checks for the wake-up sequencer.
`timescale 1ns/1ps
`include "cwss_defines.vh"
module cwss_properties #(
	parameter BANK_W = 8
) (
	// Clock and reset.
	input wire clk_sys_i,
	input wire rst_n_i,
	// Pins and strobes.
	input wire init_status_n_i,
	input wire done_pin_oe_o,
	input wire global_set_reset_n_o,
	input wire global_write_enable_o,
	input wire global_output_enable_o,
	input wire [2:0] modal_state_o,
	input wire user_mode_o,
	// Command and read paths.
	input wire [31:0] cmd_frame_o,
	input wire cmd_frame_valid_o,
	input wire cmd_nullified_o,
	input wire cmd_payload_valid_o,
	input wire nv_read_i,
	input wire nv_shadowed_i,
	input wire [31:0] nv_shadow_data_i,
	input wire [31:0] nv_read_data_o,
	input wire nv_read_valid_o,
	// Early release.
	input wire [BANK_W-1:0] bank_reg_async_i,
	input wire [BANK_W-1:0] bank_reg_set_i,
	input wire [BANK_W-1:0] bank_cfg_pin_i,
	input wire [BANK_W-1:0] bank_early_oe_o,
	input wire [BANK_W-1:0] bank_early_level_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	property p_gsr_order; $rose(global_set_reset_n_o) |-> global_output_enable_o; endproperty
	a_gsr_order: assert property (p_gsr_order) else $error("set/reset freed early");
	property p_keep; $fell(global_output_enable_o) |-> modal_state_o == 3'h0; endproperty
	a_keep: assert property (p_keep) else $error("output enable dropped outside reinit");
	property p_user;
		user_mode_o |-> global_set_reset_n_o && global_write_enable_o
			&& global_output_enable_o && !done_pin_oe_o;
	endproperty
	a_user: assert property (p_user) else $error("user mode with a strobe held");
	property p_unprog; modal_state_o == 3'h0 |-> done_pin_oe_o; endproperty
	a_unprog: assert property (p_unprog) else $error("done not low in unprogrammed");
	property p_init;
		(modal_state_o == 3'h0 && !init_status_n_i) [*3] |=> modal_state_o == 3'h0;
	endproperty
	a_init: assert property (p_init) else $error("left init with line low");
	property p_reload;
		cmd_frame_valid_o && cmd_frame_o == `CWSS_RELOAD_FRAME |=> modal_state_o == 3'h0;
	endproperty
	a_reload: assert property (p_reload) else $error("reload frame ignored");
	property p_gap; cmd_frame_valid_o |=> !cmd_frame_valid_o [*3]; endproperty
	a_gap: assert property (p_gap) else $error("frame shorter than four bytes");
	property p_null; cmd_nullified_o |-> !cmd_payload_valid_o; endproperty
	a_null: assert property (p_null) else $error("payload of nullified frame");
	property p_shadow;
		nv_read_i && nv_shadowed_i |=> nv_read_valid_o && nv_read_data_o == $past(nv_shadow_data_i);
	endproperty
	a_shadow: assert property (p_shadow) else $error("shadow not returned");
	property p_early;
		(bank_early_oe_o & (bank_cfg_pin_i | ~bank_reg_async_i
			| (bank_early_level_o ^ bank_reg_set_i))) == '0;
	endproperty
	a_early: assert property (p_early) else $error("bad early release");
	c_user: cover property ($rose(user_mode_o));
	c_reload: cover property (cmd_frame_valid_o && cmd_frame_o == `CWSS_RELOAD_FRAME);
	c_null: cover property (cmd_frame_valid_o ##1 cmd_nullified_o);
endmodule

// file: cwss_host_model.sv
// Configuration host and board model: pulled-up open-drain pins and a command byte sender.
`timescale 1ns/1ps
module cwss_host_model (
	// Clock.
	input wire clk_sys_i,
	// Open-drain pins.
	input wire done_pin_oe_o,
	input wire init_status_n_oe_o,
	output wire done_pin_i,
	output wire init_status_n_i,
	// Command byte stream.
	output logic cmd_valid_i = 1'b0,
	output logic [7:0] cmd_byte_i = 8'h00,
	output logic cmd_prog_qual_i = 1'b0,
	output logic cmd_last_i = 1'b0
);
	// The board holds init low until the host is ready.
	logic hold_init = 1'b1;
	logic hold_done = 1'b0;
	assign done_pin_i = !(done_pin_oe_o || hold_done);
	assign init_status_n_i = !(init_status_n_oe_o || hold_init);
	task send(input logic [63:0] b, input int n, input logic q);
		int i;
		for (i = 0; i < n; i++) begin
			@(posedge clk_sys_i);
			cmd_valid_i <= 1'b1;
			cmd_byte_i <= b[63 - 8 * i -: 8];
			cmd_prog_qual_i <= q;
			cmd_last_i <= (i == n - 1);
		end
		@(posedge clk_sys_i);
		cmd_valid_i <= 1'b0;
		// An idle bus must not look like a repeat of the last byte.
		cmd_byte_i <= ~cmd_byte_i;
		cmd_last_i <= 1'b0;
	endtask
endmodule

// file: test_config_wakeup_state_sequencer.sv
// Self-checking testbench of the wake-up sequencer.
`timescale 1ns/1ps
`include "cwss_defines.vh"
module test_config_wakeup_state_sequencer;
	logic clk_sys_i = 0, rst_n_i = 0, ce_i = 1;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, d;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, reprogram_request_n_i = 1, supply_low_i = 0, watchdog_trip_i = 0;
	logic reload_other_port_i = 0, partial_ok_i = 0, config_ok_i = 0, remainder_ok_i = 0;
	logic auth_pending_i = 1, bank_io_loaded_i = 0, nv_read_i = 0, nv_shadowed_i = 0;
	logic [7:0] bank_reg_async_i = 8'hF3, bank_reg_set_i = 8'h5A, bank_cfg_pin_i = 8'h81, pay_b;
	logic [31:0] nv_array_data_i = 32'h11111111, nv_shadow_data_i = 32'h22222222;
	logic [1:0] r;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata, cmd_frame_o, nv_read_data_o;
	wire init_status_n_i, init_status_n_o, init_status_n_oe_o, done_pin_i, done_pin_o;
	wire done_pin_oe_o, cmd_valid_i, cmd_prog_qual_i, cmd_last_i, cmd_ready_o;
	wire cmd_frame_valid_o, cmd_nullified_o, cmd_payload_valid_o, global_set_reset_n_o;
	wire global_write_enable_o, global_output_enable_o, sys_io_enable_o, user_mode_o;
	wire nv_read_valid_o;
	wire [7:0] cmd_byte_i, cmd_payload_o, bank_early_oe_o, bank_early_level_o;
	wire [2:0] modal_state_o;
	int mismatches = 0, checked = 0, cyc = 0, pay = 0;
	cwss_sequencer #(.BANK_W(8), .INIT_CYC(4)) cwss_sequencer_i (.*);
	cwss_host_model cwss_host_model_i (.*);
	initial forever #2.5 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cyc <= cyc + 1;
		if (cmd_payload_valid_o) begin
			pay <= pay + 1;
			pay_b <= cmd_payload_o;
		end
		if (cyc == 20000) begin
			mismatches++;
			summarize();
		end
	end
	task summarize;
		$display("checked=%0d mismatches=%0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// Ready is sampled mid-cycle; inputs only move at rising edges, so it equals the edge value.
	task axi_wr(input logic [7:0] a, input logic [31:0] v);
		logic ta, tw, tb;
		@(posedge clk_sys_i);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(negedge clk_sys_i);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clk_sys_i);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
		end while (!tb);
		s_axi_bready <= 0;
	endtask
	task axi_rd(input logic [7:0] a);
		logic ta, tr;
		@(posedge clk_sys_i);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do begin
			@(negedge clk_sys_i);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clk_sys_i);
			if (ta) s_axi_arvalid <= 0;
		end while (!tr);
		s_axi_rready <= 0;
	endtask
	task wait_st(input logic [2:0] s);
		int i;
		i = 0;
		do begin
			@(negedge clk_sys_i);
			i++;
		end while (modal_state_o !== s && i < 300);
		chk(modal_state_o, s);
	endtask
	task t_regs;
		chk({sys_io_enable_o, init_status_n_o, done_pin_o, cmd_ready_o}, 4'h1);
		axi_rd(`CWSS_OFS_CTRL);
		chk(d, `CWSS_CTRL_RST);
		axi_wr(`CWSS_OFS_STATUS, 32'h1);
		chk(r, `CWSS_RESP_SLVERR);
		axi_rd(8'h10);
		chk(r, `CWSS_RESP_SLVERR);
		chk(d, 32'h0);
		$display("register test done");
	endtask
	task t_frame(input logic [63:0] b, input int n, input logic q, input logic [31:0] ef,
			input logic nul, input int ep);
		cwss_host_model_i.send(b, n, q);
		repeat (2) @(negedge clk_sys_i);
		chk(cmd_frame_o, ef);
		chk(cmd_nullified_o, nul);
		chk(pay, ep);
		$display("frame test done");
	endtask
	task t_early;
		axi_wr(`CWSS_OFS_CTRL, 32'h08);
		repeat (2) @(negedge clk_sys_i);
		chk(bank_early_oe_o, 8'h00);
		@(posedge clk_sys_i);
		bank_io_loaded_i <= 1;
		repeat (4) @(negedge clk_sys_i);
		chk(bank_early_oe_o, 8'h72);
		chk(bank_early_oe_o & bank_early_level_o, 8'h52);
		axi_wr(`CWSS_OFS_CTRL, 32'h18);
		repeat (4) @(negedge clk_sys_i);
		chk(bank_early_oe_o, 8'h00);
		chk(sys_io_enable_o, 0);
		axi_rd(`CWSS_OFS_CTRL);
		chk(d, 32'h18);
		axi_wr(`CWSS_OFS_CTRL, 32'h38);
		repeat (2) @(negedge clk_sys_i);
		chk(sys_io_enable_o, 1);
		$display("early release test done");
	endtask
	task wake(input logic [31:0] c, input logic hold, input logic global_output_enable);
		int i;
		axi_wr(`CWSS_OFS_CTRL, c);
		wait_st(3'h1);
		@(posedge clk_sys_i);
		partial_ok_i <= 1;
		auth_pending_i <= 0;
		remainder_ok_i <= 1;
		config_ok_i <= 1;
		cwss_host_model_i.hold_done <= hold;
		i = 0;
		do begin
			@(negedge clk_sys_i);
			i++;
		end while (done_pin_oe_o !== 0 && i < 300);
		chk(global_output_enable_o, global_output_enable);
		if (hold && c[0]) begin
			repeat (40) @(negedge clk_sys_i);
			chk(user_mode_o, 0);
			@(posedge clk_sys_i) cwss_host_model_i.hold_done <= 0;
		end
		wait_st(3'h5);
		chk({global_set_reset_n_o, global_write_enable_o, global_output_enable_o,
			sys_io_enable_o}, 4'hF);
		@(posedge clk_sys_i) cwss_host_model_i.hold_done <= 0;
		$display("wake test done");
	endtask
	task t_events;
		int k;
		for (k = 0; k < 5; k++) begin
			axi_wr(`CWSS_OFS_EVENT, 32'hF);
			@(posedge clk_sys_i);
			partial_ok_i <= 0;
			remainder_ok_i <= 0;
			config_ok_i <= 0;
			auth_pending_i <= 1;
			reprogram_request_n_i <= (k != 0);
			supply_low_i <= (k == 2);
			watchdog_trip_i <= (k == 3);
			reload_other_port_i <= (k == 4);
			if (k == 1) cwss_host_model_i.send({`CWSS_RELOAD_FRAME, 32'h0}, 4, 0);
			@(posedge clk_sys_i);
			reload_other_port_i <= 0;
			watchdog_trip_i <= 0;
			wait_st(3'h0);
			chk({done_pin_oe_o, init_status_n_oe_o}, 2'h3);
			@(posedge clk_sys_i);
			reprogram_request_n_i <= 1;
			supply_low_i <= 0;
			axi_rd(`CWSS_OFS_EVENT);
			chk(d, 32'h1 << ((k == 4) ? 1 : k));
			wake(32'h0, 1, 0);
		end
		$display("exit event test done");
	endtask
	task t_nv(input logic sh, input logic [31:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		nv_shadowed_i <= sh;
		nv_array_data_i <= a;
		nv_read_i <= 1;
		@(posedge clk_sys_i) nv_read_i <= 0;
		@(negedge clk_sys_i);
		chk({nv_read_valid_o, nv_read_data_o}, {1'b1, e});
		$display("read test done");
	endtask
	task t_hold;
		@(posedge clk_sys_i);
		ce_i <= 0;
		nv_read_i <= 1;
		@(posedge clk_sys_i) nv_read_i <= 0;
		repeat (2) @(negedge clk_sys_i);
		chk({nv_read_valid_o, modal_state_o}, {1'b0, 3'h5});
		@(posedge clk_sys_i) ce_i <= 1;
		$display("clock enable test done");
	endtask
	initial begin
		repeat (12) @(posedge clk_sys_i);
		rst_n_i <= 1;
		repeat (3) @(posedge clk_sys_i);
		t_regs;
		t_frame({32'h05000000, 8'hAB, 24'h0}, 5, 1, 32'h05000000, 1, 0);
		wait_st(3'h0);
		@(posedge clk_sys_i) cwss_host_model_i.hold_init <= 0;
		wait_st(3'h1);
		t_early;
		t_frame({8'h00, 8'hFF, 8'h7F, 32'h01020304, 8'hC5}, 8, 1, 32'h01020304, 0, 1);
		chk(pay_b, 8'hC5);
		wake(`CWSS_CTRL_RST, 1, 1);
		t_frame({32'h05000000, 8'hAB, 24'h0}, 5, 1, 32'h05000000, 1, 1);
		t_nv(1, 32'h33333333, 32'h22222222);
		t_nv(0, 32'h44444444, 32'h44444444);
		t_hold;
		t_events;
		summarize();
	end
endmodule
bind cwss_sequencer cwss_properties #(.BANK_W(BANK_W)) cwss_properties_i (.*);
